//--- core/dedff_dual.sv
`timescale 1ns/100ps

// ********************************
// dual d flip-flop with set and clear overrides
// ********************************
module dedff_dual
    import dedff_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [DEDFF_CHANNELS-1:0] chan_clk,
    input wire logic [DEDFF_CHANNELS-1:0] chan_data,
    input wire logic [DEDFF_CHANNELS-1:0] async_set_n,
    input wire logic [DEDFF_CHANNELS-1:0] async_clear_n,
    output logic [DEDFF_CHANNELS-1:0] q,
    output logic [DEDFF_CHANNELS-1:0] q_bar
);

    // ********************************
    // mode decode
    // ********************************
    function automatic dedff_mode_type decode_mode(input logic set_n, input logic clear_n);
        dedff_mode_type mode;
        mode = DEDFF_MODE_CLOCKED;
        case ({set_n, clear_n})
            2'h0: mode = DEDFF_MODE_BOTH;
            2'h1: mode = DEDFF_MODE_SET;
            2'h2: mode = DEDFF_MODE_CLEAR;
            default: mode = DEDFF_MODE_CLOCKED;
        endcase
        return mode;
    endfunction : decode_mode

    // ********************************
    // pin synchronisers
    // ********************************
    // every pin is foreign to ref_clk; first stage feeds only the second
    logic [DEDFF_CHANNELS-1:0] clk_meta;
    logic [DEDFF_CHANNELS-1:0] clk_sync;
    logic [DEDFF_CHANNELS-1:0] clk_prev;
    logic [DEDFF_CHANNELS-1:0] data_meta;
    logic [DEDFF_CHANNELS-1:0] data_sync;
    logic [DEDFF_CHANNELS-1:0] set_meta;
    logic [DEDFF_CHANNELS-1:0] set_sync;
    logic [DEDFF_CHANNELS-1:0] clear_meta;
    logic [DEDFF_CHANNELS-1:0] clear_sync;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_meta <= {DEDFF_CHANNELS{DEDFF_CLK_SYNC_RESET}};
            clk_sync <= {DEDFF_CHANNELS{DEDFF_CLK_SYNC_RESET}};
            clk_prev <= {DEDFF_CHANNELS{DEDFF_CLK_SYNC_RESET}};
        end else begin
            clk_meta <= chan_clk;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            data_meta <= {DEDFF_CHANNELS{DEDFF_DATA_SYNC_RESET}};
            data_sync <= {DEDFF_CHANNELS{DEDFF_DATA_SYNC_RESET}};
        end else begin
            data_meta <= chan_data;
            data_sync <= data_meta;
        end
    end

    // overrides reset to inactive so a reset alone never looks like a set or clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            set_meta <= {DEDFF_CHANNELS{DEDFF_OVR_SYNC_RESET}};
            set_sync <= {DEDFF_CHANNELS{DEDFF_OVR_SYNC_RESET}};
            clear_meta <= {DEDFF_CHANNELS{DEDFF_OVR_SYNC_RESET}};
            clear_sync <= {DEDFF_CHANNELS{DEDFF_OVR_SYNC_RESET}};
        end else begin
            set_meta <= async_set_n;
            set_sync <= set_meta;
            clear_meta <= async_clear_n;
            clear_sync <= clear_meta;
        end
    end

    // ********************************
    // channel logic
    // ********************************
    // rising edge of a channel clock, seen through its synchroniser
    logic [DEDFF_CHANNELS-1:0] clk_rise;
    // stored bit; kept apart from q so the both-low state does not persist
    logic [DEDFF_CHANNELS-1:0] state;
    logic [DEDFF_CHANNELS-1:0] next_state;
    logic [DEDFF_CHANNELS-1:0] next_q;
    logic [DEDFF_CHANNELS-1:0] next_q_bar;

    // sync stages reset low, so a channel clock held high through reset reads as one rise
    assign clk_rise = clk_sync & ~clk_prev;

    always_comb begin
        next_state = state;
        next_q = q;
        next_q_bar = q_bar;
        for (int ch = 0; ch < DEDFF_CHANNELS; ch++) begin
            case (decode_mode(set_sync[ch], clear_sync[ch]))
                DEDFF_MODE_SET: begin
                    next_state[ch] = 1'h1;
                    next_q[ch] = 1'h1;
                    next_q_bar[ch] = 1'h0;
                end
                DEDFF_MODE_CLEAR: begin
                    next_state[ch] = 1'h0;
                    next_q[ch] = 1'h0;
                    next_q_bar[ch] = 1'h1;
                end
                DEDFF_MODE_BOTH: begin
                    next_q[ch] = 1'h1;
                    next_q_bar[ch] = 1'h1;
                end
                DEDFF_MODE_CLOCKED: begin
                    if (clk_rise[ch]) begin
                        next_state[ch] = data_sync[ch];
                    end
                    // outputs follow the stored bit; no edge means no change
                    next_q[ch] = next_state[ch];
                    next_q_bar[ch] = ~next_state[ch];
                end
                default: begin
                    next_q[ch] = state[ch];
                    next_q_bar[ch] = ~state[ch];
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= {DEDFF_CHANNELS{DEDFF_STATE_RESET}};
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= {DEDFF_CHANNELS{DEDFF_TRUE_RESET}};
            q_bar <= {DEDFF_CHANNELS{DEDFF_COMP_RESET}};
        end else begin
            q <= next_q;
            q_bar <= next_q_bar;
        end
    end

    // ********************************
    // assertions
    // ********************************
    for (genvar ch = 0; ch < DEDFF_CHANNELS; ch++) begin : g_chk
        sequence s_both_low;
            !set_sync[ch] && !clear_sync[ch];
        endsequence
        sequence s_idle;
            set_sync[ch] && clear_sync[ch] && !clk_rise[ch];
        endsequence
        sequence s_set_only;
            !set_sync[ch] && clear_sync[ch];
        endsequence

        a_set_forces_high: assert property (
            @(posedge ref_clk) disable iff (srst)
            (!set_sync[ch] && clear_sync[ch]) |=> (q[ch] && !q_bar[ch]))
            else $error("set override did not force true output high");

        a_clear_forces_low: assert property (
            @(posedge ref_clk) disable iff (srst)
            (set_sync[ch] && !clear_sync[ch]) |=> (!q[ch] && q_bar[ch]))
            else $error("clear override did not force true output low");

        a_both_low_high: assert property (
            @(posedge ref_clk) disable iff (srst)
            s_both_low |=> (q[ch] && q_bar[ch]))
            else $error("both overrides low did not drive both outputs high");

        a_both_release: assert property (
            @(posedge ref_clk) disable iff (srst)
            s_both_low ##1 s_idle |=> (q_bar[ch] == !q[ch]))
            else $error("both-high output state persisted after release");

        a_edge_capture: assert property (
            @(posedge ref_clk) disable iff (srst)
            (set_sync[ch] && clear_sync[ch] && clk_rise[ch])
                |=> (q[ch] == $past(data_sync[ch])) && (q_bar[ch] == $past(!data_sync[ch])))
            else $error("rising clock edge did not capture data");

        a_hold_idle: assert property (
            @(posedge ref_clk) disable iff (srst)
            (set_sync[ch] && clear_sync[ch]) ##1 s_idle |=> ($stable(q[ch]) && $stable(q_bar[ch])))
            else $error("outputs changed without a clock edge or override");

        a_chan_isolated: assert property (
            @(posedge ref_clk) disable iff (srst)
            (set_sync[ch] && clear_sync[ch]) ##1 s_idle |=> $stable(state[ch]))
            else $error("channel state changed by activity outside its own inputs");

        a_both_keeps_bit: assert property (
            @(posedge ref_clk) disable iff (srst)
            s_both_low |=> $stable(state[ch]))
            else $error("both overrides low changed the stored bit");

        a_set_stores_one: assert property (
            @(posedge ref_clk) disable iff (srst)
            s_set_only |=> state[ch])
            else $error("set override did not store a one");

        a_clear_stores_zero: assert property (
            @(posedge ref_clk) disable iff (srst)
            (set_sync[ch] && !clear_sync[ch]) |=> !state[ch])
            else $error("clear override did not store a zero");

        a_set_release_held: assert property (
            @(posedge ref_clk) disable iff (srst)
            s_set_only ##1 s_idle |=> (q[ch] && !q_bar[ch]))
            else $error("true output dropped after set override released");
    end

endmodule : dedff_dual

//--- core/dedff_pkg.sv

// ********************************
// constants
// ********************************
package dedff_pkg;

    localparam int DEDFF_CHANNELS = 2;

    // reset values of the per-channel state and pin synchronisers
    localparam logic DEDFF_STATE_RESET = 1'h0;
    localparam logic DEDFF_TRUE_RESET = 1'h0;
    localparam logic DEDFF_COMP_RESET = 1'h1;
    localparam logic DEDFF_CLK_SYNC_RESET = 1'h0;
    localparam logic DEDFF_DATA_SYNC_RESET = 1'h0;
    localparam logic DEDFF_OVR_SYNC_RESET = 1'h1;

    // ********************************
    // operating modes of one channel
    // ********************************
    typedef enum logic [3:0] {
        DEDFF_MODE_CLOCKED = 4'h1,
        DEDFF_MODE_SET = 4'h2,
        DEDFF_MODE_CLEAR = 4'h4,
        DEDFF_MODE_BOTH = 4'h8
    } dedff_mode_type;

endpackage : dedff_pkg

//--- sim/dedff_far.sv
`timescale 1ns/100ps
// ****
// far side logic: data source with toggle feedback
// ****
module dedff_far
    import dedff_pkg::*;
(
    input wire logic toggle,
    input wire logic [DEDFF_CHANNELS-1:0] data_in,
    input wire logic [DEDFF_CHANNELS-1:0] q_bar,
    output logic [DEDFF_CHANNELS-1:0] chan_data
);
    // complement fed back to data, so each rise inverts q
    assign chan_data = toggle ? q_bar : data_in;
endmodule : dedff_far

//--- sim/tb_top.sv
`timescale 1ns/100ps
// ****
// bench for the dual flip-flop
// ****
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
    import dedff_pkg::*;
;
    logic ref_clk = 1'h0;
    logic srst = 1'h1;
    logic toggle = 1'h0;
    logic chk = 1'h0;
    logic [1:0] chan_clk = 2'h0;
    logic [1:0] data_in = 2'h0;
    logic [1:0] set_n = 2'h3;
    logic [1:0] clear_n = 2'h3;
    logic [1:0] msk;
    logic [1:0] qn;
    logic [1:0] chan_data;
    logic [1:0] q;
    logic [1:0] q_bar;
    logic [3:0] exp_q[$];
    logic [3:0] got;
    logic [3:0] cur;
    logic [1:0] d;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;

    always #4 ref_clk = ~ref_clk;

    dedff_dual i_dut (.ref_clk(ref_clk), .srst(srst), .chan_clk(chan_clk),
        .chan_data(chan_data), .async_set_n(set_n), .async_clear_n(clear_n),
        .q(q), .q_bar(q_bar));
    dedff_far i_far (.toggle(toggle), .data_in(data_in), .q_bar(q_bar),
        .chan_data(chan_data));

    task automatic end_sim();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // pins held well past the 3-cycle latency before the note is checked
    task automatic drive(input logic [1:0] s, c, k, dv, input logic [3:0] e);
        set_n <= s;
        clear_n <= c;
        chan_clk <= k;
        data_in <= dv;
        repeat (6) @(posedge ref_clk);
        exp_q.push_back(e);
        chk <= 1'h1;
        @(posedge ref_clk);
        chk <= 1'h0;
        cur = e;
    endtask : drive

    always @(posedge ref_clk) begin
        if (chk) begin
            got = exp_q.pop_front();
            `CHK({q, q_bar}, got)
        end
    end

    // cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        d = 2'($urandom(18));
        repeat (3) @(posedge ref_clk);
        srst <= 1'h0;
        @(posedge ref_clk);
        drive(2'h3, 2'h3, 2'h0, 2'h0, 4'h3);
        drive(2'h3, 2'h0, 2'h0, 2'h0, 4'h3);
        drive(2'h2, 2'h1, 2'h0, 2'h0, 4'h6);
        drive(2'h3, 2'h3, 2'h0, 2'h0, 4'h6);
        $display("test set and clear done");
        drive(2'h2, 2'h2, 2'h0, 2'h0, 4'h7);
        drive(2'h3, 2'h3, 2'h0, 2'h0, 4'h6);
        $display("test both overrides done");
        for (int i = 0; i < 4; i++) begin
            d = 2'($urandom);
            drive(2'h3, 2'h3, 2'h0, d, cur);
            drive(2'h3, 2'h3, 2'h3, d, {d, ~d});
            drive(2'h3, 2'h3, 2'h3, ~d, cur);
            msk = 2'($urandom);
            qn = (~d & msk) | (cur[3:2] & ~msk);
            drive(2'h3, 2'h3, 2'h0, ~d, cur);
            drive(2'h3, 2'h3, msk, ~d, {qn, ~qn});
        end
        $display("test capture done");
        toggle <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            drive(2'h3, 2'h3, 2'h0, 2'h0, cur);
            drive(2'h3, 2'h3, 2'h3, 2'h0, ~cur);
        end
        $display("test toggle done");
        srst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'h0;
        drive(2'h3, 2'h3, 2'h0, 2'h0, 4'h3);
        $display("test reset done");
        end_sim();
    end
endmodule : tb_top
